// [verilog/fbdma_pkg.sv]
package fbdma_pkg;
	localparam int FBDMA_AW = 32;
	localparam int FBDMA_DW = 32;
	localparam int FBDMA_PTRS = 2;
	localparam logic [FBDMA_AW-1:0] FBDMA_ADDR_RST = 32'h0000_0000;
	localparam logic [FBDMA_AW-1:0] FBDMA_BEAT_BYTES = 32'h0000_0004;
	localparam logic FBDMA_SEL_A = 1'h0;

	// one pixel beat from the sensor side
	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic [FBDMA_DW-1:0] data;
	} fbdma_pix_s;

	// one memory write beat
	typedef struct packed {
		logic valid;
		logic [FBDMA_AW-1:0] addr;
		logic [FBDMA_DW-1:0] data;
	} fbdma_wr_s;

	typedef enum logic [0:0] {
		FBDMA_IDLE,
		FBDMA_FRAME
	} fbdma_state_e;
endpackage : fbdma_pkg

// [verilog/fbdma_ptr_bank.sv]
`timescale 1ns/10ps
module fbdma_ptr_bank
	import fbdma_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// pointer loads from the controller
	input wire logic [FBDMA_PTRS-1:0] i_load,
	input wire logic [FBDMA_AW-1:0] i_addr,
	// selected pointer
	input wire logic i_sel,
	output logic [FBDMA_AW-1:0] o_base
);
	logic [FBDMA_AW-1:0] ptr [FBDMA_PTRS];

	// one flop bank per pointer
	genvar g;
	generate
		for (g = 0; g < FBDMA_PTRS; g++) begin : g_ptr
			always_ff @(posedge i_clock or negedge i_arst_n) begin
				if (!i_arst_n) begin
					ptr[g] <= FBDMA_ADDR_RST;
				end else if (i_load[g]) begin
					ptr[g] <= i_addr;
				end
			end
		end
	endgenerate

	assign o_base = ptr[i_sel];
endmodule : fbdma_ptr_bank

// [verilog/fbdma_core.sv]
`timescale 1ns/10ps
// Contract
// - the engine keeps writing frames while i_enable is high, alternating pointers; a low i_enable blocks new frame starts.
// - a full frame buffer raises a one-cycle completion interrupt.
// - after a frame via pointer a the next uses pointer b, then a again.
// - a sink may drain the last completed buffer while the next fills.
module fbdma_core
	import fbdma_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// pointer programming
	input wire logic [FBDMA_PTRS-1:0] i_ptr_load,
	input wire logic [FBDMA_AW-1:0] i_ptr_addr,
	// capture enable and pixel stream
	input wire logic i_enable,
	input wire fbdma_pix_s i_pix,
	// memory write stream
	output fbdma_wr_s o_wr,
	// completion events
	output logic o_irq,
	output logic o_irq_ptr,
	// last completed buffer, free for the sink
	output logic o_done_valid,
	output logic [FBDMA_AW-1:0] o_done_base,
	// pointer in use
	output logic o_active_ptr
);
	fbdma_state_e state;
	logic sel;
	logic [FBDMA_AW-1:0] base;
	logic [FBDMA_AW-1:0] frame_base;
	logic [FBDMA_AW-1:0] offset;
	logic start;
	logic beat;
	logic last;

	fbdma_ptr_bank fbdma_ptr_bank_inst (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_load(i_ptr_load),
		.i_addr(i_ptr_addr),
		.i_sel(sel),
		.o_base(base)
	);

	// base is latched at frame start so late reloads hit only the next use
	assign start = i_pix.valid && i_pix.sof && i_enable;
	assign beat = i_pix.valid && (state == FBDMA_FRAME || start);
	assign last = beat && i_pix.eof;

	// frame state; a new sof restarts the frame even mid-frame
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= FBDMA_IDLE;
		end else if (last) begin
			state <= FBDMA_IDLE;
		end else if (start) begin
			state <= FBDMA_FRAME;
		end
	end

	// base and offset within the current frame
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			frame_base <= FBDMA_ADDR_RST;
			offset <= FBDMA_ADDR_RST;
		end else if (start) begin
			frame_base <= base;
			offset <= FBDMA_BEAT_BYTES;
		end else if (beat) begin
			offset <= offset + FBDMA_BEAT_BYTES;
		end
	end

	// write beats, registered straight to the port
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_wr <= '0;
		end else begin
			o_wr.valid <= beat;
			o_wr.data <= i_pix.data;
			o_wr.addr <= start ? base : frame_base + offset;
		end
	end

	// pointer alternation at each frame end, no stop between frames
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sel <= FBDMA_SEL_A;
		end else if (last) begin
			sel <= ~sel;
		end
	end

	// completion pulse and handoff of the finished buffer
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_irq <= 1'h0;
			o_irq_ptr <= FBDMA_SEL_A;
			o_done_valid <= 1'h0;
			o_done_base <= FBDMA_ADDR_RST;
		end else begin
			o_irq <= last;
			if (last) begin
				o_irq_ptr <= sel;
				o_done_valid <= 1'h1;
				o_done_base <= start ? base : frame_base;
			end
		end
	end

	// mirror of the selected pointer
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_active_ptr <= FBDMA_SEL_A;
		end else begin
			o_active_ptr <= last ? ~sel : sel;
		end
	end

	property p_irq_on_last;
		@(posedge i_clock) disable iff (!i_arst_n)
		last |=> o_irq;
	endproperty
	a_irq_on_last: assert property (p_irq_on_last)
		else $error("no irq after frame end");

	property p_irq_single;
		@(posedge i_clock) disable iff (!i_arst_n)
		o_irq |-> $past(last);
	endproperty
	a_irq_single: assert property (p_irq_single)
		else $error("irq without frame end");

	property p_alternate;
		@(posedge i_clock) disable iff (!i_arst_n)
		last |=> (sel != $past(sel));
	endproperty
	a_alternate: assert property (p_alternate)
		else $error("pointer did not alternate");

	property p_sel_hold;
		@(posedge i_clock) disable iff (!i_arst_n)
		!last |=> $stable(sel);
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("pointer changed mid frame");

	property p_start_addr;
		@(posedge i_clock) disable iff (!i_arst_n)
		start |=> (o_wr.valid && o_wr.addr == $past(base));
	endproperty
	a_start_addr: assert property (p_start_addr)
		else $error("frame start address wrong");

	property p_done_base;
		@(posedge i_clock) disable iff (!i_arst_n)
		(last && !start) |=> (o_done_base == $past(frame_base));
	endproperty
	a_done_base: assert property (p_done_base)
		else $error("completed base wrong");

	property p_irq_ptr;
		@(posedge i_clock) disable iff (!i_arst_n)
		last |=> (o_irq_ptr == $past(sel));
	endproperty
	a_irq_ptr: assert property (p_irq_ptr)
		else $error("irq pointer id wrong");

	property p_active;
		@(posedge i_clock) disable iff (!i_arst_n)
		##1 (o_active_ptr == sel);
	endproperty
	a_active: assert property (p_active)
		else $error("active pointer mirror wrong");

	property p_beat_out;
		@(posedge i_clock) disable iff (!i_arst_n)
		1'b1 |=> (o_wr.valid == $past(beat));
	endproperty
	a_beat_out: assert property (p_beat_out)
		else $error("write beat missing or extra");

	property p_addr_step;
		@(posedge i_clock) disable iff (!i_arst_n)
		(beat && !start) |=> (o_wr.addr == $past(frame_base) + $past(offset));
	endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("write address did not step");

	property p_frame_run;
		@(posedge i_clock) disable iff (!i_arst_n)
		(state == FBDMA_FRAME && !last) |=> (state == FBDMA_FRAME);
	endproperty
	a_frame_run: assert property (p_frame_run)
		else $error("frame stopped before its end");

	property p_gate;
		@(posedge i_clock) disable iff (!i_arst_n)
		(state == FBDMA_IDLE && !i_enable) |=> !o_wr.valid;
	endproperty
	a_gate: assert property (p_gate)
		else $error("write while capture is off");

	property p_done_hold;
		@(posedge i_clock) disable iff (!i_arst_n)
		!last |=> $stable(o_done_base);
	endproperty
	a_done_hold: assert property (p_done_hold)
		else $error("completed base moved mid frame");

	property p_done_sticky;
		@(posedge i_clock) disable iff (!i_arst_n)
		o_done_valid |=> o_done_valid;
	endproperty
	a_done_sticky: assert property (p_done_sticky)
		else $error("completed flag dropped");

	property p_irq_ptr_hold;
		@(posedge i_clock) disable iff (!i_arst_n)
		!last |=> $stable(o_irq_ptr);
	endproperty
	a_irq_ptr_hold: assert property (p_irq_ptr_hold)
		else $error("irq pointer id moved");
endmodule : fbdma_core

// [verif/fbdma_cam_model.sv]
`timescale 1ns/10ps
module fbdma_cam_model
	import fbdma_pkg::*;
(
	// clock
	input wire logic i_clock,
	// frame request
	input wire logic i_go,
	input wire logic [7:0] i_frames,
	input wire logic [7:0] i_len,
	// pixel beats
	output fbdma_pix_s o_pix,
	output logic o_busy
);
	// frames back to back; idle data toggles so it never looks stale
	initial begin
		o_pix = '0;
		o_busy = 1'b0;
		forever begin
			if (i_go) begin
				o_busy <= 1'b1;
				for (int f = 0; f < i_frames; f++) begin
					for (int b = 0; b < i_len; b++) begin
						o_pix <= '{1'b1, b == 0, b == i_len - 1, {f[15:0], b[15:0]}};
						@(negedge i_clock);
					end
				end
			end
			o_pix.valid <= 1'b0;
			o_pix.data <= ~o_pix.data;
			o_busy <= 1'b0;
			@(negedge i_clock);
		end
	end
endmodule : fbdma_cam_model

// [verif/frame_buffer_ping_pong_dma_tb.sv]
`timescale 1ns/10ps
module frame_buffer_ping_pong_dma_tb;
	import fbdma_pkg::*;
	logic i_clock = 1'b0, i_arst_n = 1'b0, i_enable = 1'b0, go = 1'b0, busy;
	logic [1:0] i_ptr_load = '0, ld_bits = '0;
	logic [31:0] i_ptr_addr = '0, ld_addr = '0, done_base;
	logic [7:0] n_frames = 8'h00, len = 8'h03;
	logic irq, irq_ptr, done_valid, active_ptr;
	fbdma_pix_s pix;
	fbdma_wr_s wr;
	int errors = 0, n_tests = 0, cycles = 0, beats = 0, fr = 0, bt = 0;
	// four buffers rotate through the two pointers
	logic [31:0] ring [4] = '{32'h1000_0000, 32'h1001_0000,
		32'h1002_0000, 32'h1003_0000};
	always #2 i_clock = ~i_clock;
	fbdma_core fbdma_core_inst (.i_clock(i_clock), .i_arst_n(i_arst_n),
		.i_ptr_load(i_ptr_load), .i_ptr_addr(i_ptr_addr), .i_enable(i_enable),
		.i_pix(pix), .o_wr(wr), .o_irq(irq), .o_irq_ptr(irq_ptr),
		.o_done_valid(done_valid), .o_done_base(done_base),
		.o_active_ptr(active_ptr));
	fbdma_cam_model fbdma_cam_model_inst (.i_clock(i_clock), .i_go(go),
		.i_frames(n_frames), .i_len(len), .o_pix(pix), .o_busy(busy));
	task compare(input string what, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : compare
	task print_verdict;
		$display("comparisons %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	// sample at the falling edge where outputs are settled; act as controller
	always @(negedge i_clock) begin
		cycles++;
		if (i_arst_n && wr.valid) begin
			beats++;
			compare("addr", wr.addr, ring[fr % 4] + FBDMA_BEAT_BYTES * bt);
			compare("data", {16'h0, wr.data[15:0]}, bt);
			bt++;
		end
		if (i_arst_n && irq) begin
			compare("irq at full", bt, len);
			compare("irq ptr", irq_ptr, fr % 2);
			compare("done base", done_base, ring[fr % 4]);
			compare("done valid", done_valid, 1);
			compare("active ptr", active_ptr, (fr + 1) % 2);
			// finished pointer moves two buffers on; next frame uses the other
			i_ptr_load <= irq_ptr ? 2'h2 : 2'h1;
			i_ptr_addr <= ring[(fr + 2) % 4];
			fr++;
			bt = 0;
		end else begin
			i_ptr_load <= ld_bits;
			i_ptr_addr <= ld_addr;
			ld_bits = '0;
		end
		// ceiling far above the fewer than one hundred cycles the scenarios need
		if (cycles == 3000) begin
			errors++;
			print_verdict();
		end
	end
	task send(input logic [7:0] n);
		@(negedge i_clock);
		n_frames <= n;
		go <= 1'b1;
		while (!busy) @(negedge i_clock);
		go <= 1'b0;
		while (busy) @(negedge i_clock);
		repeat (4) @(negedge i_clock);
	endtask : send
	task load_ring;
		for (int p = 0; p < 2; p++) begin
			@(posedge i_clock);
			ld_bits = 2'(p + 1);
			ld_addr = ring[p];
		end
		repeat (2) @(negedge i_clock);
	endtask : load_ring
	// capture off: a whole frame is dropped
	task gated_frame;
		send(8'h01);
		compare("gated beats", beats, 0);
		compare("no done yet", done_valid, 0);
	endtask : gated_frame
	// five frames back to back wrap the ring once
	task ring_frames;
		i_enable <= 1'b1;
		send(8'h05);
		compare("frames", fr, 5);
		compare("beats", beats, 15);
	endtask : ring_frames
	// one-beat frames, sof and eof on the same beat
	task short_frames;
		len <= 8'h01;
		send(8'h02);
		compare("short frames", fr, 7);
		compare("short beats", beats, 17);
	endtask : short_frames
	initial begin
		repeat (20) @(negedge i_clock);
		i_arst_n <= 1'b1;
		load_ring();
		gated_frame();
		ring_frames();
		short_frames();
		print_verdict();
	end
endmodule : frame_buffer_ping_pong_dma_tb
